// ### drive_prot_pkg.sv
/*
 * Shared constants of the drive protection and torque monitor block:
 * register offsets, field positions, setting codes, thresholds and the
 * detection time step. Assumes a 100 MHz control clock.
 */
package drive_prot_pkg;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_OVER_CFG  = 8'h04;
    localparam logic [7:0] ADDR_OVER_TIME = 8'h08;
    localparam logic [7:0] ADDR_LOW_CFG   = 8'h0C;
    localparam logic [7:0] ADDR_LOW_TIME  = 8'h10;
    localparam logic [7:0] ADDR_STATUS    = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT  = 8'h18;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h20;
    localparam logic [7:0] ADDR_FAULT_RST = 8'h24;

    // Control register bits
    localparam int CTRL_REG_OFF  = 0;
    localparam int CTRL_SUPPLY   = 1;
    localparam int CTRL_MOTOR    = 2;
    localparam int CTRL_VECTOR   = 3;

    // Detection config fields
    localparam int CFG_SEL_LSB   = 0;
    localparam int CFG_RESP_LSB  = 8;
    localparam int CFG_LVL_LSB   = 16;
    localparam int LVL_W         = 9;
    localparam int TIME_W        = 7;

    // Writable bits and reset values
    localparam logic [31:0] CTRL_MASK  = 32'h0000_000F;
    localparam logic [31:0] CFG_MASK   = 32'h01FF_0303;
    localparam logic [31:0] TIME_MASK  = 32'h0000_007F;
    localparam logic [31:0] IRQ_MASK   = 32'h0000_000F;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // Selection and response codes
    localparam logic [1:0] SEL_OFF   = 2'h0;
    localparam logic [1:0] SEL_SPEED = 2'h1;
    localparam logic [1:0] SEL_RUN   = 2'h2;
    localparam logic [1:0] RESP_DEC  = 2'h0;
    localparam logic [1:0] RESP_WARN = 2'h1;
    localparam logic [1:0] RESP_COAST = 2'h2;

    // Limits in percent and tenths of a second
    localparam logic [LVL_W-1:0]  LVL_MAX  = 9'h12C;
    localparam logic [TIME_W-1:0] TIME_MAX = 7'h64;
    localparam int SUPPLY_MIN_PCT = 30;
    localparam int MOTOR_MIN_PCT  = 10;

    // Detection time step
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_NS       = 100_000_000;
    localparam int STEP_CYCLES   = STEP_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        FAULT_NONE,
        FAULT_SUPPLY,
        FAULT_MOTOR,
        FAULT_OVER,
        FAULT_LOW
    } fault_t;

endpackage

// ### torque_qualifier.sv
/*
 * Qualifies a level excursion of the monitored current or torque over a
 * programmed time in 0.1 s steps. Assumes tick_i pulses once per step.
 */
`timescale 1ns/10ps

module torque_qualifier
    import drive_prot_pkg::*;
#(
    parameter int MEAS_W = 10,
    parameter bit ABOVE  = 1'b1
)
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Step and arming
    input  wire logic              tick_i,
    input  wire logic              armed_i,
    // Measurement and settings
    input  wire logic [MEAS_W-1:0] value_i,
    input  wire logic [LVL_W-1:0]  level_i,
    input  wire logic [TIME_W-1:0] time_i,
    // Result
    output logic                   detected_o
);

    logic [TIME_W-1:0] count_q;
    logic [TIME_W-1:0] count_d;
    logic              cond;
    logic [MEAS_W-1:0] level_w;

    assign level_w = MEAS_W'(level_i);
    assign cond    = armed_i &&
                     (ABOVE ? (value_i > level_w) : (value_i < level_w));
    // Timer restarts on every new excursion
    assign count_d = !cond ? '0 :
                     (tick_i && count_q < time_i) ? count_q + 1'b1 :
                     count_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_q    <= '0;
            detected_o <= 1'b0;
        end
        else
        begin
            count_q    <= count_d;
            detected_o <= cond && (count_q >= time_i);
        end
    end

    // Detection only follows a qualifying excursion
    held_cond_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(detected_o) |-> $past(cond) && $past(count_q >= time_i))
        else $error("detection without a qualified excursion");

    drop_warn_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !cond |=> !detected_o)
        else $error("detection held after the condition ended");

    if (MEAS_W < LVL_W)
    begin : g_width_chk
        $error("MEAS_W too narrow for the detection level");
    end

endmodule // torque_qualifier

// ### drive_prot_monitor.sv
/*
 * Protection and supervision logic of a motor drive: voltage regulation
 * enable, supply and motor phase loss trips, over and low torque
 * detection with fault or warning responses, Wishbone register slave and
 * interrupt. Assumes measurements in percent of rated value, synchronous
 * to clk_i, and a power stage that obeys the stop outputs.
 */
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/10ps

// Operation
// - Setting 0 regulates output voltage, 1 follows supply
// - Supply phase loss trips output, fault contact
// - Supply loss ignored below 30% current
// - Motor phase loss trips output, fault contact
// - Motor loss ignored below 10% current
// - Over-torque arm: off, at speed, running
// - Over-torque response: decelerate, warn, coast
// - Over-torque level 0 to 300 percent
// - Over-torque time 0.0 to 10.0 s
// - Low-torque arm: off, at speed, running
// - Low-torque response: decelerate, warn, coast
// - Over on rise, low on fall
// - Current reference under V/f, torque under vector
// - Over-torque needs continuous excursion for time
// - Low-torque needs continuous excursion for time
module drive_prot_monitor
    import drive_prot_pkg::*;
#(
    parameter int MEAS_W      = 10,
    parameter int TICK_CYCLES = STEP_CYCLES
)
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    // Power stage status
    input  wire logic [MEAS_W-1:0] current_pct_i,
    input  wire logic [MEAS_W-1:0] torque_pct_i,
    input  wire logic              running_i,
    input  wire logic              at_speed_i,
    input  wire logic              supply_phase_lost_i,
    input  wire logic              motor_phase_lost_i,
    // Drive commands and indications
    output logic                   voltage_regulation_en_o,
    output logic                   output_off_o,
    output logic                   decel_stop_o,
    output logic                   fault_contact_o,
    output logic [2:0]             fault_code_o,
    output logic                   over_warn_o,
    output logic                   low_warn_o,
    output logic                   irq_o
);

    localparam int TCW = $clog2(TICK_CYCLES + 1);

    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    function automatic logic armed(input logic [1:0] sel,
                                   input logic       run,
                                   input logic       spd);
        armed = (sel == SEL_SPEED) ? (run && spd) :
                (sel == SEL_RUN)   ? run : 1'b0;
    endfunction

    // Registers
    logic [31:0]  ctrl_q;
    logic [31:0]  cfg_q [2];
    logic [31:0]  time_q [2];
    logic [3:0]   irq_stat_q;
    logic [3:0]   irq_en_q;
    logic [TCW-1:0] tick_cnt_q;
    logic         tick_q;
    logic [1:0]   det_q;
    fault_t       fault_q;
    fault_t       fault_d;
    logic         coast_q;
    logic         coast_d;

    // Bus decode
    logic        req;
    logic        wr;
    logic [31:0] wmask;
    logic        wr_ctrl;
    logic        wr_cfg [2];
    logic        wr_time [2];
    logic        wr_irq_clr;
    logic        wr_irq_en;
    logic        wr_fault_rst;
    logic [31:0] rd_data;
    logic [31:0] status_w;

    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr      = req && wb_we_i;
    assign wmask   = lane_mask(wb_sel_i);
    assign wr_ctrl = wr && (wb_adr_i == ADDR_CTRL);
    assign wr_cfg[0]  = wr && (wb_adr_i == ADDR_OVER_CFG);
    assign wr_cfg[1]  = wr && (wb_adr_i == ADDR_LOW_CFG);
    assign wr_time[0] = wr && (wb_adr_i == ADDR_OVER_TIME);
    assign wr_time[1] = wr && (wb_adr_i == ADDR_LOW_TIME);
    assign wr_irq_clr = wr && (wb_adr_i == ADDR_IRQ_CLR) && wb_sel_i[0];
    assign wr_irq_en  = wr && (wb_adr_i == ADDR_IRQ_EN) && wb_sel_i[0];
    assign wr_fault_rst = wr && (wb_adr_i == ADDR_FAULT_RST) &&
                          wb_sel_i[0] && wb_dat_i[0];

    // Unmapped offsets and the clear registers read as zero
    assign rd_data =
        (wb_adr_i == ADDR_CTRL)      ? ctrl_q :
        (wb_adr_i == ADDR_OVER_CFG)  ? cfg_q[0] :
        (wb_adr_i == ADDR_OVER_TIME) ? time_q[0] :
        (wb_adr_i == ADDR_LOW_CFG)   ? cfg_q[1] :
        (wb_adr_i == ADDR_LOW_TIME)  ? time_q[1] :
        (wb_adr_i == ADDR_STATUS)    ? status_w :
        (wb_adr_i == ADDR_IRQ_STAT)  ? {28'h000_0000, irq_stat_q} :
        (wb_adr_i == ADDR_IRQ_EN)    ? {28'h000_0000, irq_en_q} :
        32'h0000_0000;

    assign status_w = {23'h00_0000, output_off_o, decel_stop_o,
                       fault_code_o, fault_contact_o, det_q,
                       voltage_regulation_en_o};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_q <= RESET_WORD;
        else if (wr_ctrl)
            ctrl_q <= ((ctrl_q & ~wmask) | (wb_dat_i & wmask)) & CTRL_MASK;
    end

    // Time step for the qualification timers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end
        else
        begin
            tick_q     <= (tick_cnt_q == TCW'(TICK_CYCLES - 1));
            tick_cnt_q <= (tick_cnt_q == TCW'(TICK_CYCLES - 1)) ?
                          '0 : tick_cnt_q + 1'b1;
        end
    end

    logic [MEAS_W-1:0] meas;
    assign meas = ctrl_q[CTRL_VECTOR] ? torque_pct_i : current_pct_i;

    logic [1:0] sel_w  [2];
    logic [1:0] resp_w [2];
    logic       det_w  [2];

    // Index 0 watches rises, index 1 falls
    for (genvar i = 0; i < 2; i++)
    begin : g_det
        logic [LVL_W-1:0]  lvl_raw;
        logic [LVL_W-1:0]  lvl;
        logic [TIME_W-1:0] tm_raw;
        logic [TIME_W-1:0] tm;

        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                cfg_q[i]  <= RESET_WORD;
                time_q[i] <= RESET_WORD;
            end
            else
            begin
                if (wr_cfg[i])
                    cfg_q[i] <= ((cfg_q[i] & ~wmask) |
                                 (wb_dat_i & wmask)) & CFG_MASK;
                if (wr_time[i])
                    time_q[i] <= ((time_q[i] & ~wmask) |
                                  (wb_dat_i & wmask)) & TIME_MASK;
            end
        end

        assign sel_w[i]  = cfg_q[i][CFG_SEL_LSB +: 2];
        assign resp_w[i] = cfg_q[i][CFG_RESP_LSB +: 2];
        assign lvl_raw   = cfg_q[i][CFG_LVL_LSB +: LVL_W];
        assign tm_raw    = time_q[i][TIME_W-1:0];
        assign lvl = (lvl_raw > LVL_MAX) ? LVL_MAX : lvl_raw;
        assign tm  = (tm_raw > TIME_MAX) ? TIME_MAX : tm_raw;

        torque_qualifier #(
            .MEAS_W (MEAS_W),
            .ABOVE  (i == 0)
        ) u_qual (
            .clk_i      (clk_i),
            .rst_i      (rst_i),
            .tick_i     (tick_q),
            .armed_i    (armed(sel_w[i], running_i, at_speed_i)),
            .value_i    (meas),
            .level_i    (lvl),
            .time_i     (tm),
            .detected_o (det_w[i])
        );
    end

    // Phase loss checks gated by output current
    logic supply_trip;
    logic motor_trip;
    logic over_trip;
    logic low_trip;

    assign supply_trip = ctrl_q[CTRL_SUPPLY] && supply_phase_lost_i &&
                         (current_pct_i >= MEAS_W'(SUPPLY_MIN_PCT));
    assign motor_trip  = ctrl_q[CTRL_MOTOR] && motor_phase_lost_i &&
                         (current_pct_i >= MEAS_W'(MOTOR_MIN_PCT));
    assign over_trip   = det_w[0] && (resp_w[0] != RESP_WARN);
    assign low_trip    = det_w[1] && (resp_w[1] != RESP_WARN);

    // First trip wins and stays until reset; a trip present in the
    // reset cycle is latched again so no event is lost.
    always_comb
    begin
        fault_d = fault_q;
        coast_d = coast_q;
        if (fault_q == FAULT_NONE || wr_fault_rst)
        begin
            fault_d = FAULT_NONE;
            coast_d = 1'b0;
            if (supply_trip)
            begin
                fault_d = FAULT_SUPPLY;
                coast_d = 1'b1;
            end
            else if (motor_trip)
            begin
                fault_d = FAULT_MOTOR;
                coast_d = 1'b1;
            end
            else if (over_trip)
            begin
                fault_d = FAULT_OVER;
                coast_d = (resp_w[0] == RESP_COAST);
            end
            else if (low_trip)
            begin
                fault_d = FAULT_LOW;
                coast_d = (resp_w[1] == RESP_COAST);
            end
        end
    end

    logic [3:0] irq_ev;
    assign irq_ev = {det_w[1] && !det_q[1], det_w[0] && !det_q[0],
                     motor_trip, supply_trip};

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fault_q    <= FAULT_NONE;
            coast_q    <= 1'b0;
            det_q      <= 2'h0;
            irq_stat_q <= 4'h0;
            irq_en_q   <= 4'h0;
        end
        else
        begin
            fault_q <= fault_d;
            coast_q <= coast_d;
            det_q   <= {det_w[1], det_w[0]};
            // New events win over a clear in the same cycle
            irq_stat_q <= irq_ev | (irq_stat_q &
                          ~(wr_irq_clr ? wb_dat_i[3:0] : 4'h0));
            if (wr_irq_en)
                irq_en_q <= wb_dat_i[3:0] & IRQ_MASK[3:0];
        end
    end

    // Indication and command flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            voltage_regulation_en_o <= 1'b1;
            output_off_o    <= 1'b0;
            decel_stop_o    <= 1'b0;
            fault_contact_o <= 1'b0;
            fault_code_o    <= 3'h0;
            over_warn_o     <= 1'b0;
            low_warn_o      <= 1'b0;
            irq_o           <= 1'b0;
        end
        else
        begin
            voltage_regulation_en_o <= !ctrl_q[CTRL_REG_OFF];
            output_off_o    <= (fault_q != FAULT_NONE) && coast_q;
            decel_stop_o    <= (fault_q != FAULT_NONE) && !coast_q;
            fault_contact_o <= (fault_q != FAULT_NONE);
            fault_code_o    <= fault_q;
            over_warn_o <= det_w[0] && (resp_w[0] == RESP_WARN);
            low_warn_o  <= det_w[1] && (resp_w[1] == RESP_WARN);
            irq_o       <= |(irq_stat_q & irq_en_q);
        end
    end

    ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    ack_latency_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not answered in one cycle");

    regulation_off_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (wr_ctrl && wb_sel_i[0] && wb_dat_i[CTRL_REG_OFF])
        |=> ##1 !voltage_regulation_en_o)
        else $error("regulation still enabled after setting 1");

    supply_gate_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (fault_d == FAULT_SUPPLY && fault_q != FAULT_SUPPLY) |->
        (current_pct_i >= MEAS_W'(SUPPLY_MIN_PCT)) && supply_phase_lost_i)
        else $error("supply loss latched below 30 percent");

    motor_gate_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (fault_d == FAULT_MOTOR && fault_q != FAULT_MOTOR) |->
        (current_pct_i >= MEAS_W'(MOTOR_MIN_PCT)) && ctrl_q[CTRL_MOTOR])
        else $error("motor loss latched below 10 percent or disabled");

    phase_trip_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (fault_q == FAULT_SUPPLY || fault_q == FAULT_MOTOR) |=>
        output_off_o && fault_contact_o && !decel_stop_o)
        else $error("phase loss did not turn the output off");

    warn_only_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (det_w[0] && resp_w[0] == RESP_WARN) |=> over_warn_o)
        else $error("over-torque warning missing");

    arm_off_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        (sel_w[0] == SEL_OFF) [*2] |-> !det_w[0])
        else $error("over-torque detected while disabled");

    if (TICK_CYCLES < 2)
    begin : g_tick_chk
        $error("TICK_CYCLES must be at least 2");
    end

endmodule // drive_prot_monitor

// ### power_stage_model.sv
/*
 * Behavioural power stage beside the protection monitor: runs on request,
 * stops while the monitor commands a stop, reports current, torque and
 * phase loss. Assumes registered stop commands on the same clock.
 */
`timescale 1ns/10ps

module power_stage_model
#(
    parameter int MEAS_W = 10
)
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Operator requests
    input  wire logic              run_req_i,
    input  wire logic              speed_req_i,
    input  wire logic [MEAS_W-1:0] current_set_i,
    input  wire logic [MEAS_W-1:0] torque_set_i,
    input  wire logic              supply_loss_i,
    input  wire logic              motor_loss_i,
    // Monitor commands
    input  wire logic              output_off_i,
    input  wire logic              decel_stop_i,
    // Status to the monitor
    output logic                   running_o,
    output logic                   at_speed_o,
    output logic [MEAS_W-1:0]      current_pct_o,
    output logic [MEAS_W-1:0]      torque_pct_o,
    output logic                   supply_phase_lost_o,
    output logic                   motor_phase_lost_o
);
    logic run_q;
    logic spd_q;
    wire  run_d = run_req_i & ~output_off_i & ~decel_stop_i;

    always_ff @(posedge clk_i)
    begin
        run_q <= ~rst_i & run_d;
        spd_q <= ~rst_i & run_d & speed_req_i;
    end

    // A stopped stage draws no current, so stopping also disarms detection
    assign running_o           = run_q;
    assign at_speed_o          = spd_q;
    assign current_pct_o       = run_q ? current_set_i : '0;
    assign torque_pct_o        = run_q ? torque_set_i : '0;
    assign supply_phase_lost_o = supply_loss_i;
    assign motor_phase_lost_o  = motor_loss_i;
endmodule // power_stage_model

// ### testbench.sv
/*
 * Self-checking bench of the drive protection monitor.
 * Assumes the power stage model beside it and a 100 MHz clock.
 */
`timescale 1ns/10ps

module testbench
    import drive_prot_pkg::*;
;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic        run_req = 1'b0;
    logic        spd_req = 1'b0;
    logic        sup_loss = 1'b0;
    logic        mot_loss = 1'b0;
    logic [9:0]  cur_set = 10'h000;
    logic [9:0]  trq_set = 10'h000;
    logic        running, at_speed, sup_lost, mot_lost;
    logic [9:0]  cur, trq;
    logic        vreg, off, decel, fcon, owarn, lwarn, irq;
    logic [2:0]  fcode;
    int          bad_count = 0;
    int          comparisons = 0;

    always #5 clk_i = ~clk_i;

    power_stage_model #(.MEAS_W(10)) stage (.clk_i(clk_i), .rst_i(rst_i),
        .run_req_i(run_req), .speed_req_i(spd_req), .current_set_i(cur_set),
        .torque_set_i(trq_set), .supply_loss_i(sup_loss),
        .motor_loss_i(mot_loss), .output_off_i(off), .decel_stop_i(decel),
        .running_o(running), .at_speed_o(at_speed), .current_pct_o(cur),
        .torque_pct_o(trq), .supply_phase_lost_o(sup_lost),
        .motor_phase_lost_o(mot_lost));

    // Short tick keeps detection times to a few cycles
    drive_prot_monitor #(.MEAS_W(10), .TICK_CYCLES(4)) DUT (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .current_pct_i(cur), .torque_pct_i(trq),
        .running_i(running), .at_speed_i(at_speed),
        .supply_phase_lost_i(sup_lost), .motor_phase_lost_i(mot_lost),
        .voltage_regulation_en_o(vreg), .output_off_o(off),
        .decel_stop_o(decel), .fault_contact_o(fcon), .fault_code_o(fcode),
        .over_warn_o(owarn), .low_warn_o(lwarn), .irq_o(irq));

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check_bit(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic check_word(input string what, input logic [31:0] e,
                              input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Classic cycle held until ack is sampled, then released
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        q = rdat;
        check_bit("bus ack", 1'b1, ack);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [31:0] e,
                            input string what);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        check_word(what, e, q);
    endtask

    function automatic logic [31:0] cfg(input logic [1:0] s,
                                        input logic [1:0] r,
                                        input logic [8:0] l);
        return {7'h00, l, 6'h00, r, 6'h00, s};
    endfunction

    task automatic test_regs();
        check_bit("regulation reset", 1'b1, vreg);
        rd_check(ADDR_CTRL, 32'h0000_0000, "ctrl reset");
        rd_check(8'h3C, 32'h0000_0000, "unmapped read");
        wr(ADDR_CTRL, 32'h0000_0001);
        cycles(3);
        check_bit("regulation off", 1'b0, vreg);
        wr(ADDR_CTRL, 32'h0000_0000);
        cycles(3);
        check_bit("regulation on", 1'b1, vreg);
        rd_check(ADDR_STATUS, 32'h0000_0001, "status");
        $display("register test done");
    endtask

    task automatic phase_case(input logic m);
        int lim = m ? MOTOR_MIN_PCT : SUPPLY_MIN_PCT;
        run_req <= 1'b1;
        cur_set <= 10'(lim + 20);
        sup_loss <= ~m;
        mot_loss <= m;
        cycles(8);
        check_bit("loss disabled", 1'b0, fcon);
        cur_set <= 10'(lim - 1);
        wr(ADDR_CTRL, m ? 32'h0000_0004 : 32'h0000_0002);
        cycles(8);
        check_bit("loss low current", 1'b0, fcon);
        cur_set <= 10'(lim);
        cycles(6);
        check_word("loss code", m ? 32'h0000_0002 : 32'h0000_0001,
                   32'(fcode));
        check_bit("loss off", 1'b1, off);
        check_bit("loss contact", 1'b1, fcon);
        check_bit("irq masked", 1'b0, irq);
        rd_check(ADDR_IRQ_STAT, m ? 32'h0000_0002 : 32'h0000_0001, "irq st");
        wr(ADDR_IRQ_EN, 32'h0000_000F);
        cycles(2);
        check_bit("irq raised", 1'b1, irq);
        sup_loss <= 1'b0;
        mot_loss <= 1'b0;
        cycles(2);
        wr(ADDR_FAULT_RST, 32'h0000_0001);
        wr(ADDR_IRQ_CLR, 32'h0000_000F);
        cycles(3);
        check_bit("fault cleared", 1'b0, fcon);
        check_bit("irq cleared", 1'b0, irq);
        wr(ADDR_IRQ_EN, 32'h0000_0000);
        wr(ADDR_CTRL, 32'h0000_0000);
        $display("phase loss test done");
    endtask

    task automatic torque_case(input logic lo, input logic [1:0] r);
        logic [7:0] ca = lo ? ADDR_LOW_CFG : ADDR_OVER_CFG;
        logic [9:0] ex = lo ? 10'h063 : 10'h065;
        run_req <= 1'b1;
        cur_set <= 10'h064;
        wr(lo ? ADDR_LOW_TIME : ADDR_OVER_TIME, 32'h0000_0002);
        wr(ca, cfg(SEL_RUN, r, 9'h064));
        cycles(20);
        check_bit("at level", 1'b0, lo ? lwarn : owarn);
        cur_set <= ex;
        cycles(3);
        cur_set <= 10'h064;
        cycles(4);
        check_bit("short excursion", 1'b0, fcon | owarn | lwarn);
        cur_set <= ex;
        cycles(20);
        check_bit("warn", r == RESP_WARN, lo ? lwarn : owarn);
        check_bit("decel", r == RESP_DEC, decel);
        check_bit("coast", r == RESP_COAST, off);
        check_word("torque code", r == RESP_WARN ? 32'h0000_0000 : lo ?
                   32'h0000_0004 : 32'h0000_0003, 32'(fcode));
        cur_set <= 10'h064;
        cycles(4);
        check_bit("warn drop", 1'b0, lo ? lwarn : owarn);
        wr(ca, 32'h0000_0000);
        cycles(2);
        wr(ADDR_FAULT_RST, 32'h0000_0001);
        cycles(3);
        check_bit("torque cleared", 1'b0, fcon);
        $display("torque test done");
    endtask

    task automatic arm_case();
        wr(ADDR_OVER_TIME, 32'h0000_0064);
        rd_check(ADDR_OVER_TIME, 32'h0000_0064, "time readback");
        wr(ADDR_OVER_CFG, cfg(SEL_RUN, RESP_WARN, 9'h064));
        cur_set <= 10'h096;
        cycles(380);
        check_bit("long time early", 1'b0, owarn);
        cycles(40);
        check_bit("long time done", 1'b1, owarn);
        wr(ADDR_OVER_TIME, 32'h0000_0000);
        wr(ADDR_LOW_CFG, cfg(SEL_SPEED, RESP_WARN, 9'h1FF));
        wr(ADDR_OVER_CFG, cfg(SEL_SPEED, RESP_WARN, 9'h064));
        cycles(20);
        check_bit("below speed", 1'b0, owarn);
        check_bit("low below speed", 1'b0, lwarn);
        spd_req <= 1'b1;
        cycles(20);
        check_bit("at speed", 1'b1, owarn);
        check_bit("low at speed", 1'b1, lwarn);
        wr(ADDR_OVER_CFG, cfg(SEL_OFF, RESP_WARN, 9'h064));
        cycles(5);
        check_bit("select off", 1'b0, owarn);
        wr(ADDR_OVER_CFG, cfg(SEL_RUN, RESP_WARN, LVL_MAX));
        cur_set <= 10'h12C;
        cycles(10);
        check_bit("level max equal", 1'b0, owarn);
        cur_set <= 10'h12D;
        cycles(10);
        check_bit("level max above", 1'b1, owarn);
        wr(ADDR_OVER_CFG, cfg(SEL_RUN, RESP_WARN, 9'h064));
        cur_set <= 10'h032;
        trq_set <= 10'h096;
        cycles(10);
        check_bit("current reference", 1'b0, owarn);
        wr(ADDR_CTRL, 32'h0000_0008);
        cycles(10);
        check_bit("torque reference", 1'b1, owarn);
        cur_set <= 10'h096;
        trq_set <= 10'h032;
        cycles(10);
        check_bit("torque ignores current", 1'b0, owarn);
        $display("arming test done");
    endtask

    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        test_regs();
        phase_case(1'b0);
        phase_case(1'b1);
        for (int r = 0; r < 3; r++)
        begin
            torque_case(1'b0, 2'(r));
            torque_case(1'b1, 2'(r));
        end
        arm_case();
        stop_test();
    end

    // Whole run needs about a thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        $display("[FAIL] watchdog expected done seen hang");
        stop_test();
    end
endmodule // testbench
